/* File: rtl/cfw_pkg.sv */
/*
 cfw_pkg: shared constants and types for the processor flag word block.
 Assumes a single clock and a synchronous active-low reset in every user.
*/
package cfw_pkg;
    // flag word bit positions
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned DEBUG_BIT = 1;
    localparam int unsigned ZERO_BIT = 2;
    localparam int unsigned SIGN_BIT = 3;
    localparam int unsigned BANK_BIT = 4;
    localparam int unsigned OVFL_BIT = 5;
    localparam int unsigned IEN_BIT = 6;
    localparam int unsigned STKSEL_BIT = 7;
    localparam int unsigned PRIO_LSB = 8;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned RSVD_BIT = 11;
    localparam int unsigned WORD_W = 11;
    localparam int unsigned BUS_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned TRAP_W = 6;
    // register offsets on the software port
    localparam logic [3:0] FLAG_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h1;
    // reset values
    localparam logic [10:0] FLAG_RST = 11'h000;
    // highest trap vector that also forces the interrupt stack
    localparam logic [5:0] TRAP_ISP_MAX = 6'h1F;
    // alu operation classes
    typedef enum logic [1:0] {
        CFW_OP_NONE,
        CFW_OP_ARITH,
        CFW_OP_LOGIC,
        CFW_OP_SHIFT
    } cfw_op_type;
endpackage : cfw_pkg

/* File: rtl/cfw_alu_if.sv */
/*
 cfw_alu_if: result bundle from the flag evaluator to the flag word core.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cfw_alu_if;
    logic upd;
    logic carry;
    logic zero;
    logic sign;
    logic ovfl;
    logic ovfl_only;
    modport src (output upd, output carry, output zero, output sign, output ovfl,
        output ovfl_only);
    modport dst (input upd, input carry, input zero, input sign, input ovfl,
        input ovfl_only);
endinterface : cfw_alu_if
`default_nettype wire

/* File: rtl/cfw_eval.sv */
/*
 cfw_eval: derives result flags from an alu result, purely combinational.
 Assumes the result, carry-out and overflow come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cfw_eval (
    // alu result
    input wire cfw_pkg::cfw_op_type op,
    input wire logic [15:0] result,
    input wire logic carry_out,
    input wire logic overflow,
    // derived flags
    cfw_alu_if.src res
);
    // logic ops leave carry alone in the core; here only compute values
    assign res.upd = (op != cfw_pkg::CFW_OP_NONE);
    assign res.carry = carry_out;
    assign res.zero = (result == 16'h0000);
    assign res.sign = result[cfw_pkg::DATA_W-1];
    assign res.ovfl = overflow;
    assign res.ovfl_only = (op == cfw_pkg::CFW_OP_LOGIC);
endmodule : cfw_eval
`default_nettype wire

/* File: rtl/cfw_accept.sv */
/*
 cfw_accept: maskable interrupt acceptance decision.
 Assumes request level and flags are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cfw_accept (
    // request
    input wire logic req,
    input wire logic [2:0] req_level,
    // current flag state
    input wire logic ien,
    input wire logic [2:0] prio,
    // decision
    output logic take
);
    // strictly above the current level, and only when enabled
    assign take = req && ien && (req_level > prio);
endmodule : cfw_accept
`default_nettype wire

/* File: rtl/cfw_flag_word.sv */
/*
 cfw_flag_word: the processor flag word with result, bank, stack select,
 interrupt enable and priority level, plus the interrupt acceptance check.
 Assumes the alu, sequencer and acknowledge logic share the clock; software
 reaches the word over a plain strobe port with read data one cycle later.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
// How it works
// - sign flag follows result sign bit of each arithmetic operation
// - bank select bit 0 picks bank 0, 1 picks bank 1
// - overflow flag set on overflow, cleared otherwise
// - maskable interrupts blocked while enable is 0
// - any interrupt acknowledge clears the enable flag
// - stack select 0 picks interrupt stack, 1 picks user stack
// - stack select cleared by hardware acknowledge or trap vector 0..31
// - priority level is three bits, levels 0 to 7
// - request accepted only above the current priority level
// - reserved bit reads undefined (here zero), writes should be zero
// - flag word holds eleven bits
// - carry flag captures alu carry, borrow or shift-out
// - zero flag set when result is zero
`timescale 1ns/1ps
`default_nettype none
module cfw_flag_word (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // alu result
    input wire cfw_pkg::cfw_op_type alu_op,
    input wire logic [15:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    // sequencer control writes
    input wire logic bank_wr,
    input wire logic bank_val,
    input wire logic ien_set,
    input wire logic ien_clr,
    input wire logic stk_wr,
    input wire logic stk_val,
    input wire logic prio_wr,
    input wire logic [2:0] prio_val,
    // interrupt path
    input wire logic irq_req,
    input wire logic [2:0] irq_level,
    input wire logic nmi_ack,
    input wire logic trap_exec,
    input wire logic [5:0] trap_vec,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // state outputs
    output logic [10:0] cpu_flag_word,
    output logic bank_sel,
    output logic use_user_stack,
    output logic irq_take
);
    logic [10:0] flag_r;
    logic [10:0] flag_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic take_r;
    logic take_w;
    logic ack_any;
    logic stk_clear;
    logic sw_flag_wr;
    logic sw_flag_rd;
    logic sw_stat_rd;
    logic [2:0] prio_now;

    cfw_alu_if alu_res ();

    // flag derivation from the alu result
    cfw_eval u_eval (
        .op(alu_op),
        .result(alu_result),
        .carry_out(alu_carry),
        .overflow(alu_overflow),
        .res(alu_res)
    );

    // acceptance uses next-state flags so a just-finished update counts
    cfw_accept u_accept (
        .req(irq_req),
        .req_level(irq_level),
        .ien(flag_nxt[cfw_pkg::IEN_BIT]),
        .prio(prio_now),
        .take(take_w)
    );

    // address decode and acknowledge sources
    assign prio_now = flag_nxt[cfw_pkg::PRIO_LSB +: cfw_pkg::PRIO_W];
    assign sw_flag_wr = reg_wr && (reg_addr == cfw_pkg::FLAG_OFS);
    assign sw_flag_rd = reg_rd && (reg_addr == cfw_pkg::FLAG_OFS);
    assign sw_stat_rd = reg_rd && (reg_addr == cfw_pkg::STATUS_OFS);
    assign ack_any = take_r || nmi_ack;
    // hardware acknowledge or low trap vector forces the interrupt stack
    assign stk_clear = ack_any || (trap_exec && (trap_vec <= cfw_pkg::TRAP_ISP_MAX));

    // next flag word: software write first, then hardware, acknowledge last wins
    always_comb
    begin
        flag_nxt = flag_r;
        if (sw_flag_wr)
        begin
            flag_nxt = reg_wdata[cfw_pkg::WORD_W-1:0];
        end
        if (alu_res.upd)
        begin
            flag_nxt[cfw_pkg::OVFL_BIT] = alu_res.ovfl;
            flag_nxt[cfw_pkg::ZERO_BIT] = alu_res.zero;
            flag_nxt[cfw_pkg::SIGN_BIT] = alu_res.sign;
            // logic ops do not produce a carry, so keep it
            if (!alu_res.ovfl_only)
            begin
                flag_nxt[cfw_pkg::CARRY_BIT] = alu_res.carry;
            end
        end
        if (bank_wr)
        begin
            flag_nxt[cfw_pkg::BANK_BIT] = bank_val;
        end
        if (stk_wr)
        begin
            flag_nxt[cfw_pkg::STKSEL_BIT] = stk_val;
        end
        if (prio_wr)
        begin
            flag_nxt[cfw_pkg::PRIO_LSB +: cfw_pkg::PRIO_W] = prio_val;
        end
        if (ien_set)
        begin
            flag_nxt[cfw_pkg::IEN_BIT] = 1'h1;
        end
        if (ien_clr || ack_any)
        begin
            flag_nxt[cfw_pkg::IEN_BIT] = 1'h0;
        end
        if (stk_clear)
        begin
            flag_nxt[cfw_pkg::STKSEL_BIT] = 1'h0;
        end
    end

    // read mux; reserved bit and upper bits read as zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (sw_flag_rd)
        begin
            rdata_nxt = {5'h00, flag_r};
        end
        else if (sw_stat_rd)
        begin
            rdata_nxt = {12'h000, 1'h0, take_r, flag_r[cfw_pkg::STKSEL_BIT],
                flag_r[cfw_pkg::BANK_BIT]};
        end
    end

    // state registers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            flag_r <= cfw_pkg::FLAG_RST;
            rdata_r <= 16'h0000;
            take_r <= 1'h0;
        end
        else
        begin
            flag_r <= flag_nxt;
            rdata_r <= rdata_nxt;
            take_r <= take_w && !take_r;
        end
    end

    // outputs straight from flops
    assign cpu_flag_word = flag_r;
    assign bank_sel = flag_r[cfw_pkg::BANK_BIT];
    assign use_user_stack = flag_r[cfw_pkg::STKSEL_BIT];
    assign irq_take = take_r;
    assign reg_rdata = rdata_r;

    // checks
    sign_track_a: assert property (@(posedge clock) disable iff (!nrst)
        (alu_op == cfw_pkg::CFW_OP_ARITH && !sw_flag_wr) |=>
        cpu_flag_word[cfw_pkg::SIGN_BIT] == $past(alu_result[15]))
        else $error("sign flag wrong");
    ovfl_track_a: assert property (@(posedge clock) disable iff (!nrst)
        (alu_op != cfw_pkg::CFW_OP_NONE) |=>
        cpu_flag_word[cfw_pkg::OVFL_BIT] == $past(alu_overflow))
        else $error("overflow flag wrong");
    zero_track_a: assert property (@(posedge clock) disable iff (!nrst)
        (alu_op != cfw_pkg::CFW_OP_NONE) |=>
        cpu_flag_word[cfw_pkg::ZERO_BIT] == ($past(alu_result) == 16'h0000))
        else $error("zero flag wrong");
    carry_track_a: assert property (@(posedge clock) disable iff (!nrst)
        (alu_op == cfw_pkg::CFW_OP_ARITH) |=>
        cpu_flag_word[cfw_pkg::CARRY_BIT] == $past(alu_carry))
        else $error("carry flag wrong");
    take_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        irq_take |-> $past(irq_req) && $past(irq_level) > $past(prio_now))
        else $error("interrupt taken at too low a level");
    take_mask_a: assert property (@(posedge clock) disable iff (!nrst)
        irq_take |-> $past(flag_nxt[cfw_pkg::IEN_BIT]))
        else $error("interrupt taken while disabled");
    ack_clear_a: assert property (@(posedge clock) disable iff (!nrst)
        irq_take |=> !cpu_flag_word[cfw_pkg::IEN_BIT] && !use_user_stack)
        else $error("acknowledge did not clear enable and stack");
    trap_stack_a: assert property (@(posedge clock) disable iff (!nrst)
        (trap_exec && trap_vec <= 6'h1F) |=> !use_user_stack)
        else $error("trap did not select interrupt stack");
    bank_out_a: assert property (@(posedge clock) disable iff (!nrst)
        bank_wr && !sw_flag_wr |=> bank_sel == $past(bank_val))
        else $error("bank select not written");
    rsvd_read_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_rd |=> reg_rdata[15:11] == 5'h00)
        else $error("reserved bits not zero");

    take_seen_c: cover property (@(posedge clock) disable iff (!nrst) irq_take);
    trap_seen_c: cover property (@(posedge clock) disable iff (!nrst)
        trap_exec && use_user_stack);
    sw_write_c: cover property (@(posedge clock) disable iff (!nrst) sw_flag_wr);
    blocked_c: cover property (@(posedge clock) disable iff (!nrst)
        irq_req && !take_w);
endmodule : cfw_flag_word
`default_nettype wire

/* File: dv/cfw_irq_src.sv */
/*
 cfw_irq_src: model of the interrupt source facing the flag word.
 Assumes the block's clock; the bench raises want and picks the level.
*/
`timescale 1ns/1ps
`default_nettype none
module cfw_irq_src (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // bench control
    input wire logic want,
    input wire logic [2:0] lvl,
    // request side
    input wire logic irq_take,
    output logic irq_req,
    output logic [2:0] irq_level
);
    logic done_r;
    // request drops on take and stays down until want falls
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            irq_req <= 1'b0;
            done_r <= 1'b0;
            irq_level <= 3'h0;
        end
        else
        begin
            done_r <= want && (done_r || irq_take);
            irq_req <= want && !done_r && !irq_take;
            irq_level <= want ? lvl : ~irq_level; // toggles when idle, never trusted
        end
    end
endmodule : cfw_irq_src
`default_nettype wire

/* File: dv/tb.sv */
/*
 tb: self-checking bench for the flag word.
 Assumes cfw_flag_word and cfw_irq_src beside it on one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0, nrst = 1'b0, want = 1'b0, bank_wr = 1'b0, bank_val = 1'b0;
    logic ien_set = 1'b0, ien_clr = 1'b0, stk_wr = 1'b0, stk_val = 1'b0, prio_wr = 1'b0;
    logic nmi_ack = 1'b0, trap_exec = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic alu_carry = 1'b0, alu_overflow = 1'b0, irq_req, bank_sel, use_user_stack, irq_take;
    logic [2:0] prio_val = 3'h0, lvl = 3'h0, irq_level;
    logic [5:0] trap_vec = 6'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] alu_result = 16'h0000, reg_wdata = 16'h0000, reg_rdata, seed = 16'h571A, r;
    logic [10:0] cpu_flag_word, exp_w = 11'h000;
    cfw_pkg::cfw_op_type alu_op = cfw_pkg::CFW_OP_NONE, op;
    int error_cnt = 0, num_checks = 0, takes = 0;
    cfw_flag_word u_cfw_flag_word (.clock(clock), .nrst(nrst), .alu_op(alu_op),
        .alu_result(alu_result), .alu_carry(alu_carry), .alu_overflow(alu_overflow),
        .bank_wr(bank_wr), .bank_val(bank_val), .ien_set(ien_set), .ien_clr(ien_clr),
        .stk_wr(stk_wr), .stk_val(stk_val), .prio_wr(prio_wr), .prio_val(prio_val),
        .irq_req(irq_req), .irq_level(irq_level), .nmi_ack(nmi_ack), .trap_exec(trap_exec),
        .trap_vec(trap_vec), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_flag_word(cpu_flag_word),
        .bank_sel(bank_sel), .use_user_stack(use_user_stack), .irq_take(irq_take));
    cfw_irq_src u_cfw_irq_src (.clock(clock), .nrst(nrst), .want(want), .lvl(lvl),
        .irq_take(irq_take), .irq_req(irq_req), .irq_level(irq_level));
    // clock and acceptance counter
    always #5 clock = ~clock;
    always @(posedge clock)
        if (irq_take === 1'b1)
            takes <= takes + 1;
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : xs
    // expected word after one alu result; logic ops keep carry
    function automatic logic [10:0] nxt_alu(input cfw_pkg::cfw_op_type o, input logic [15:0] v,
        input logic [10:0] w);
        logic [10:0] n;
        n = w;
        if (o != cfw_pkg::CFW_OP_NONE)
        begin
            n[cfw_pkg::OVFL_BIT] = v[9];
            n[cfw_pkg::ZERO_BIT] = (v == 16'h0000);
            n[cfw_pkg::SIGN_BIT] = v[15];
        end
        if (o == cfw_pkg::CFW_OP_ARITH || o == cfw_pkg::CFW_OP_SHIFT)
            n[cfw_pkg::CARRY_BIT] = v[5];
        return n;
    endfunction : nxt_alu
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // ends every pulse after one cycle, then lets outputs settle
    task automatic go();
        @(posedge clock);
        alu_op <= cfw_pkg::CFW_OP_NONE;
        bank_wr <= 1'b0;
        stk_wr <= 1'b0;
        prio_wr <= 1'b0;
        ien_set <= 1'b0;
        ien_clr <= 1'b0;
        nmi_ack <= 1'b0;
        trap_exec <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : go
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        go();
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        go();
        chk(reg_rdata, e);
    endtask : rd
    // field strobes: set enable and user stack, optionally load a level
    task automatic arm(input logic pw, input logic [2:0] pv);
        @(posedge clock);
        ien_set <= 1'b1;
        stk_wr <= 1'b1;
        stk_val <= 1'b1;
        prio_wr <= pw;
        prio_val <= pv;
        go();
    endtask : arm
    // five cycles cover request, take and the flag clear that follows
    task automatic irq(input logic [2:0] lv, input logic tk);
        int n;
        n = takes;
        @(posedge clock);
        want <= 1'b1;
        lvl <= lv;
        repeat (5) @(posedge clock);
        want <= 1'b0;
        #1;
        chk(16'(takes - n), {15'h0000, tk});
    endtask : irq
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        #1;
        chk({5'h00, cpu_flag_word}, 16'h0000);
        for (int i = 0; i < 24; i++)
        begin
            r = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : xs();
            op = (i < 2) ? cfw_pkg::CFW_OP_ARITH : cfw_pkg::cfw_op_type'(r[3:2]);
            @(posedge clock);
            alu_op <= op;
            alu_result <= r;
            alu_carry <= r[5];
            alu_overflow <= r[9];
            exp_w = nxt_alu(op, r, exp_w);
            go();
            chk({5'h00, cpu_flag_word}, {5'h00, exp_w});
        end
        r = xs() & 16'hF7FD;
        wr(cfw_pkg::FLAG_OFS, r);
        rd(cfw_pkg::FLAG_OFS, {5'h00, r[10:0]});
        wr(4'h7, 16'h07FF);
        rd(4'h5, 16'h0000);
        rd(cfw_pkg::STATUS_OFS, {13'h0000, 1'b0, r[7], r[4]});
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            bank_wr <= 1'b1;
            bank_val <= i[0];
            stk_wr <= 1'b1;
            stk_val <= i[0];
            go();
            chk({14'h0000, bank_sel, use_user_stack}, {14'h0000, i[0], i[0]});
            arm(1'b0, 3'h0);
            @(posedge clock);
            trap_exec <= 1'b1;
            trap_vec <= i[0] ? 6'h20 : 6'h1F;
            go();
            chk({15'h0000, use_user_stack}, {15'h0000, i[0]});
        end
        arm(1'b0, 3'h0);
        @(posedge clock);
        nmi_ack <= 1'b1;
        go();
        chk({14'h0000, cpu_flag_word[7:6]}, 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            arm(1'b1, i[2:0]);
            irq(i[2:0], 1'b0);
            irq(i[2:0] + 3'h1, 1'b1);
            chk({14'h0000, cpu_flag_word[7:6]}, 16'h0000);
            irq(3'h7, 1'b0);
        end
        arm(1'b1, 3'h0);
        @(posedge clock);
        ien_clr <= 1'b1;
        go();
        irq(3'h3, 1'b0);
        end_sim();
    end
endmodule : tb
`default_nettype wire
